/* rtl/axis_homing_sequencer.sv */
// Purpose: Homing sequencer for one servo axis, methods 11 to 19
// Assumes: Switch and index pins are asynchronous, position is on core_clk_i
// Notes: Unsupported or reserved methods are refused with a one-cycle pulse
// Notes on behaviour
// - M11 switch off: negative fast, reverse slow
// - M11 switch on: positive slow, index after release
// - M12 switch off: slow on switch, index
// - M12/M13 switch on: slow, reverse on release
// - M12 limit: reverse fast, cross switch edges
// - M13 switch off: negative, then slow index
// - M13 limit: reverse fast, slow on switch
// - M14 switch off: slow on switch, index
// - M14 switch on: negative slow, index after release
// - M14 limit: reverse, reverse again on switch
// - Methods 15 and 16 are refused
// - Methods 17 up ignore the index pulse
// - M17 limit off: negative, reverse on limit
// - M17 limit on: positive slow, home on release
// - M18 limit off: positive, reverse on limit
// - M18 limit on: negative slow, home on release
// - M19 switch off: positive, reverse on switch
// - M19 switch on: negative slow, home on release
`timescale 1ns/10ps
`include "homing_defs.svh"

module axis_homing_sequencer
  import homing_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // Command from the controller program
  input wire logic homing_command_i,
  input wire home_cfg_t cfg_i,
  // Axis feedback
  input wire logic home_sw_i,
  input wire logic neg_limit_i,
  input wire logic pos_limit_i,
  input wire logic index_i,
  input wire logic [`HS_POS_W-1:0] position_i,
  // Drive and status
  output motion_t motion_o,
  output logic busy_o,
  output logic done_o,
  output logic refused_o,
  output logic [`HS_POS_W-1:0] home_pos_o
);

  // Synchroniser chain per pin and the filtered level
  logic [`HS_NPINS-1:0] pins_w;
  logic [`HS_NPINS-1:0] sync1_reg;
  logic [`HS_NPINS-1:0] sync2_reg;
  logic [`HS_NPINS-1:0] sync3_reg;
  logic [`HS_NPINS-1:0] filt_reg;
  logic [`HS_NPINS-1:0] rise_w;
  logic [`HS_NPINS-1:0] fall_w;

  // Sequencer state
  home_state_t state_reg;
  home_state_t state_next;
  logic dir_reg; // Direction, high is positive
  logic dir_next;
  logic fast_reg; // High while at first-phase speed
  logic fast_next;
  logic rev_reg; // Reverse when the switch releases
  logic rev_next;
  home_cfg_t cfg_reg;
  logic accept_w; // Command taken this cycle
  logic refuse_w; // Command refused this cycle
  logic latch_w; // Home position taken this cycle
  logic start_on_w; // Watched switch active at command
  logic watch_rise_w;
  logic watch_fall_w;

  assign pins_w = {index_i, pos_limit_i, neg_limit_i, home_sw_i};

  // Three-stage synchroniser, a change counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < `HS_NPINS; gi = gi + 1) begin : g_sync
      always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
          sync3_reg[gi] <= 1'b0;
          filt_reg[gi] <= 1'b0;
        end else begin
          sync1_reg[gi] <= pins_w[gi];
          sync2_reg[gi] <= sync1_reg[gi];
          sync3_reg[gi] <= sync2_reg[gi];
          if (sync2_reg[gi] == sync3_reg[gi]) begin
            filt_reg[gi] <= sync3_reg[gi];
          end
        end
      end
      // Edges of the filtered level
      assign rise_w[gi] = (sync2_reg[gi] == sync3_reg[gi]) & sync3_reg[gi] & ~filt_reg[gi];
      assign fall_w[gi] = (sync2_reg[gi] == sync3_reg[gi]) & ~sync3_reg[gi] & filt_reg[gi];
    end
  endgenerate

  // Switch that the method watches: limit for 17 and 18, else home switch
  function automatic logic [1:0] watch_sel(input logic [`HS_METHOD_W-1:0] m);
    if (m == `HS_M17) begin
      watch_sel = 2'h1;
    end else if (m == `HS_M18) begin
      watch_sel = 2'h2;
    end else begin
      watch_sel = 2'h0;
    end
  endfunction

  // Start level from the live method, edges from the captured method
  always_comb begin
    start_on_w = filt_reg[watch_sel(cfg_i.method)];
    watch_rise_w = rise_w[watch_sel(cfg_reg.method)];
    watch_fall_w = fall_w[watch_sel(cfg_reg.method)];
  end

  assign accept_w = homing_command_i && (state_reg == ST_IDLE || state_reg == ST_DONE);

  // Next-state decisions for every method
  always_comb begin
    state_next = state_reg;
    dir_next = dir_reg;
    fast_next = fast_reg;
    rev_next = rev_reg;
    refuse_w = 1'b0;
    latch_w = 1'b0;
    case (state_reg)
      ST_IDLE, ST_DONE: begin
        if (accept_w) begin
          rev_next = 1'b0;
          fast_next = 1'b0;
          state_next = ST_SLOW;
          case (cfg_i.method)
            `HS_M11: begin
              if (start_on_w) begin
                dir_next = 1'b1;
              end else begin
                state_next = ST_FAST;
                dir_next = 1'b0;
                fast_next = 1'b1;
              end
            end
            `HS_M12, `HS_M13: begin
              if (start_on_w) begin
                dir_next = (cfg_i.method == `HS_M12);
                rev_next = 1'b1;
              end else begin
                state_next = ST_FAST;
                dir_next = 1'b0;
                fast_next = 1'b1;
              end
            end
            `HS_M14: begin
              if (start_on_w) begin
                dir_next = 1'b0;
              end else begin
                state_next = ST_FAST;
                dir_next = 1'b0;
                fast_next = 1'b1;
              end
            end
            `HS_M17, `HS_M18, `HS_M19: begin
              if (start_on_w) begin
                dir_next = (cfg_i.method == `HS_M17);
              end else begin
                state_next = ST_FAST;
                dir_next = (cfg_i.method != `HS_M17);
                fast_next = 1'b1;
              end
            end
            default: begin
              state_next = state_reg;
              dir_next = dir_reg;
              fast_next = fast_reg;
              rev_next = rev_reg;
              refuse_w = 1'b1;
            end
          endcase
        end
      end
      ST_FAST: begin
        if (watch_rise_w) begin
          fast_next = 1'b0;
          case (cfg_reg.method)
            `HS_M11, `HS_M17: begin
              state_next = ST_SLOW;
              dir_next = 1'b1;
            end
            `HS_M12, `HS_M13: begin
              state_next = ST_WAITZ;
            end
            `HS_M14: begin
              state_next = ST_SLOW;
            end
            default: begin
              state_next = ST_SLOW;
              dir_next = 1'b0;
            end
          endcase
        end else if (rise_w[`HS_BIT_NLIM] && cfg_reg.method <= `HS_M14) begin
          state_next = ST_LIMREV;
          dir_next = 1'b1;
        end
      end
      ST_LIMREV: begin
        if (rise_w[`HS_BIT_HOME] && cfg_reg.method == `HS_M13 && !filt_reg[`HS_BIT_NLIM]) begin
          state_next = ST_WAITZ;
          fast_next = 1'b0;
        end else if (rise_w[`HS_BIT_HOME] && cfg_reg.method == `HS_M14) begin
          state_next = ST_SLOW;
          dir_next = 1'b0;
          fast_next = 1'b0;
        end else if (fall_w[`HS_BIT_HOME]) begin
          state_next = ST_FAST;
          dir_next = 1'b0;
        end
      end
      ST_SLOW: begin
        if (watch_fall_w) begin
          if (cfg_reg.method >= `HS_M17) begin
            state_next = ST_DONE;
            latch_w = 1'b1;
          end else begin
            state_next = ST_WAITZ;
            if (rev_reg) begin
              dir_next = ~dir_reg;
            end
          end
        end
      end
      ST_WAITZ: begin
        if (rise_w[`HS_BIT_INDEX]) begin
          state_next = ST_DONE;
          latch_w = 1'b1;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // State and direction registers
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg <= ST_IDLE;
      dir_reg <= 1'b0;
      fast_reg <= 1'b0;
      rev_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      dir_reg <= dir_next;
      fast_reg <= fast_next;
      rev_reg <= rev_next;
    end
  end

  // Configuration captured with an accepted command
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cfg_reg <= '{`HS_RST_METHOD, `HS_RST_SPEED, `HS_RST_SPEED};
    end else if (accept_w && !refuse_w) begin
      cfg_reg <= cfg_i;
    end
  end

  // Drive command, stopped outside a run
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      motion_o <= '{1'b0, 1'b0, `HS_RST_SPEED};
    end else begin
      motion_o.enable <= (state_next != ST_IDLE) && (state_next != ST_DONE);
      motion_o.dir_pos <= dir_next;
      if (state_next == ST_IDLE || state_next == ST_DONE) begin
        motion_o.speed <= `HS_RST_SPEED;
      end else if (accept_w) begin
        motion_o.speed <= fast_next ? cfg_i.speed_first : cfg_i.speed_second;
      end else begin
        motion_o.speed <= fast_next ? cfg_reg.speed_first : cfg_reg.speed_second;
      end
    end
  end

  // Home position latch and status
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      home_pos_o <= `HS_RST_POS;
      done_o <= 1'b0;
      refused_o <= 1'b0;
    end else begin
      if (latch_w) begin
        home_pos_o <= position_i;
      end
      done_o <= (state_next == ST_DONE);
      refused_o <= refuse_w;
    end
  end

  assign busy_o = motion_o.enable;

  // Checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  property p_m11_off_start;
    accept_w && cfg_i.method == `HS_M11 && !filt_reg[`HS_BIT_HOME]
      |=> motion_o.enable && !motion_o.dir_pos && motion_o.speed == $past(cfg_i.speed_first);
  endproperty
  a_m11_off_start: assert property (p_m11_off_start) else $error("M11 start not negative fast");

  property p_m11_on_start;
    accept_w && cfg_i.method == `HS_M11 && filt_reg[`HS_BIT_HOME]
      |=> motion_o.dir_pos && motion_o.speed == $past(cfg_i.speed_second) && state_reg == ST_SLOW;
  endproperty
  a_m11_on_start: assert property (p_m11_on_start) else $error("M11 active start wrong");

  property p_reserved;
    accept_w && (cfg_i.method == `HS_M15 || cfg_i.method == `HS_M16)
      |=> refused_o && !motion_o.enable ##1 !refused_o;
  endproperty
  a_reserved: assert property (p_reserved) else $error("Reserved method not refused");

  property p_no_index_wait;
    state_reg == ST_WAITZ |-> cfg_reg.method <= `HS_M14 && motion_o.speed == cfg_reg.speed_second;
  endproperty
  a_no_index_wait: assert property (p_no_index_wait) else $error("Index wait outside 11 to 14");

  property p_index_latch;
    state_reg == ST_WAITZ && rise_w[`HS_BIT_INDEX]
      |=> done_o && !motion_o.enable && home_pos_o == $past(position_i);
  endproperty
  a_index_latch: assert property (p_index_latch) else $error("Index did not latch home");

  property p_m17_reverse;
    state_reg == ST_FAST && cfg_reg.method == `HS_M17 && rise_w[`HS_BIT_NLIM]
      |=> motion_o.dir_pos && motion_o.speed == cfg_reg.speed_second;
  endproperty
  a_m17_reverse: assert property (p_m17_reverse) else $error("M17 did not reverse slow");

  property p_switch_latch;
    state_reg == ST_SLOW && cfg_reg.method >= `HS_M17 && watch_fall_w
      |=> state_reg == ST_DONE && home_pos_o == $past(position_i);
  endproperty
  a_switch_latch: assert property (p_switch_latch) else $error("Switch release did not latch");

  property p_release_reverse;
    state_reg == ST_SLOW && rev_reg && watch_fall_w
      |=> state_reg == ST_WAITZ && motion_o.dir_pos != $past(motion_o.dir_pos);
  endproperty
  a_release_reverse: assert property (p_release_reverse) else $error("No reversal on release");

  property p_m14_limit_again;
    state_reg == ST_LIMREV && cfg_reg.method == `HS_M14 && rise_w[`HS_BIT_HOME]
      |=> !motion_o.dir_pos && state_reg == ST_SLOW ##1 motion_o.enable;
  endproperty
  a_m14_limit_again: assert property (p_m14_limit_again) else $error("M14 limit path wrong");

  property p_limit_reverse;
    state_reg == ST_FAST && cfg_reg.method == `HS_M12 && rise_w[`HS_BIT_NLIM] && !watch_rise_w
      |=> motion_o.dir_pos && motion_o.speed == cfg_reg.speed_first;
  endproperty
  a_limit_reverse: assert property (p_limit_reverse) else $error("Limit reversal wrong");

endmodule // axis_homing_sequencer

/* rtl/homing_defs.svh */
// Purpose: Widths, method codes and reset values for the homing sequencer
// Assumes: Included by its bare name wherever the numbers are needed
// Notes: Definitions only
`ifndef HOMING_DEFS_SVH
`define HOMING_DEFS_SVH

// Data widths
`define HS_SPEED_W 16
`define HS_POS_W 32
`define HS_METHOD_W 8

// Homing method numbers
`define HS_M11 8'h0b
`define HS_M12 8'h0c
`define HS_M13 8'h0d
`define HS_M14 8'h0e
`define HS_M15 8'h0f
`define HS_M16 8'h10
`define HS_M17 8'h11
`define HS_M18 8'h12
`define HS_M19 8'h13

// Switch field positions in the synchronised pin vector
`define HS_BIT_HOME 0
`define HS_BIT_NLIM 1
`define HS_BIT_PLIM 2
`define HS_BIT_INDEX 3
`define HS_NPINS 4

// Reset values
`define HS_RST_POS 32'h0000_0000
`define HS_RST_SPEED 16'h0000
`define HS_RST_METHOD 8'h00

`endif

/* rtl/homing_pkg.sv */
// Purpose: Types shared by the homing sequencer
// Assumes: homing_defs.svh gives the widths
// Notes: Types only, numbers stay in the header
`include "homing_defs.svh"

package homing_pkg;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_FAST   = 3'b001,
    ST_LIMREV = 3'b010,
    ST_SLOW   = 3'b011,
    ST_WAITZ  = 3'b100,
    ST_DONE   = 3'b101
  } home_state_t;

  // Drive command toward the servo axis
  typedef struct packed {
    logic enable;
    logic dir_pos;
    logic [`HS_SPEED_W-1:0] speed;
  } motion_t;

  // Homing configuration captured with the command
  typedef struct packed {
    logic [`HS_METHOD_W-1:0] method;
    logic [`HS_SPEED_W-1:0] speed_first;
    logic [`HS_SPEED_W-1:0] speed_second;
  } home_cfg_t;

endpackage

/* verif/servo_axis_model.sv */
// Purpose: Behavioural servo axis with index and switches
// Assumes: Position moves by the commanded speed each cycle
// Notes: Switch levels come from fixed position windows
`timescale 1ns/10ps
`include "homing_defs.svh"

module servo_axis_model
  import homing_pkg::*;
#(
  parameter int HOME_LO = 1000, // Home switch window start
  parameter int HOME_HI = 1100, // Home switch window end
  parameter int NEG_EDGE = 500, // Negative limit below this
  parameter int POS_EDGE = 1600 // Positive limit above this
)(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // Drive and bench placement
  input wire motion_t motion_i,
  input wire logic load_i,
  input wire logic [`HS_POS_W-1:0] load_pos_i,
  // Feedback toward the sequencer
  output logic home_sw_o,
  output logic neg_limit_o,
  output logic pos_limit_o,
  output logic index_o,
  output logic [`HS_POS_W-1:0] position_o
);
  // Position integrates the commanded speed
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      position_o <= '0;
    end else if (load_i) begin
      position_o <= load_pos_i;
    end else if (motion_i.enable) begin
      position_o <= motion_i.dir_pos ? position_o + motion_i.speed : position_o - motion_i.speed;
    end
  end

  // Switch levels from position windows
  assign home_sw_o = (position_o >= HOME_LO) && (position_o <= HOME_HI);
  assign neg_limit_o = position_o < NEG_EDGE;
  assign pos_limit_o = position_o > POS_EDGE;
  // Index tooth eight counts wide every 64 counts
  assign index_o = position_o[5:0] < 6'h08;
endmodule // servo_axis_model

/* verif/tb.sv */
// Purpose: Self-checking bench for the homing sequencer
// Assumes: Axis model supplies switches, index and position
// Notes: Phases are coded as direction and slow-speed flag
`timescale 1ns/10ps
`include "homing_defs.svh"

module tb;
  import homing_pkg::*;
  localparam logic [15:0] SP1 = 16'h0004; // First-phase speed
  localparam logic [15:0] SP2 = 16'h0001; // Second-phase speed
  localparam int LIMIT = 40000; // Cycle ceiling
  logic core_clk = 1'b0; // Clock
  logic rst_b = 1'b0; // Reset, active low
  logic cmd = 1'b0; // Homing command
  home_cfg_t cfg = '0; // Configuration
  logic load = 1'b0; // Axis placement strobe
  logic [31:0] load_pos = '0; // Axis placement value
  logic home_sw, neg_limit, pos_limit, index; // Axis feedback
  logic [31:0] position, home_pos; // Positions
  motion_t motion; // Drive command
  logic busy, done, refused; // Status
  int fails = 0; // Mismatches
  int num_checks = 0; // Comparisons
  int cycles = 0; // Timeout counter

  axis_homing_sequencer dut_u (.core_clk_i(core_clk), .rst_b_i(rst_b), .homing_command_i(cmd),
    .cfg_i(cfg), .home_sw_i(home_sw), .neg_limit_i(neg_limit), .pos_limit_i(pos_limit),
    .index_i(index), .position_i(position), .motion_o(motion), .busy_o(busy), .done_o(done),
    .refused_o(refused), .home_pos_o(home_pos));

  servo_axis_model axis_u (.core_clk_i(core_clk), .rst_b_i(rst_b), .motion_i(motion),
    .load_i(load), .load_pos_i(load_pos), .home_sw_o(home_sw), .neg_limit_o(neg_limit),
    .pos_limit_o(pos_limit), .index_o(index), .position_o(position));

  // Clock and hang guard
  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      fails++;
      final_report();
    end
  end

  // Compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Place the axis and let the switch filters settle
  task automatic place(input int start);
    @(posedge core_clk);
    #1;
    load = 1'b1;
    load_pos = start;
    @(posedge core_clk);
    #1;
    load = 1'b0;
    repeat (6) @(posedge core_clk);
    #1;
  endtask

  // One homing run: record phases, judge the end state
  task automatic run(input logic [7:0] method, input int start, input logic [7:0] exp_ph,
                     input int exp_n, input int lo, input int hi);
    logic [7:0] ph;
    logic [1:0] code;
    int n;
    ph = '0;
    n = 0;
    place(start);
    cmd = 1'b1;
    cfg = '{method, SP1, SP2};
    @(posedge core_clk);
    #1;
    cmd = 1'b0;
    cfg = '{method, 16'h00ff, 16'h00ee};
    for (int k = 0; k < 3000 && done !== 1'b1; k++) begin
      if (motion.enable === 1'b1) begin
        code = {motion.dir_pos, motion.speed === SP2};
        if (motion.speed !== SP2) check("phase speed", motion.speed, SP1);
        if (n == 0 || code != ph[1:0]) begin
          ph = {ph[5:0], code};
          n++;
        end
      end
      @(posedge core_clk);
      #1;
    end
    check("done", done, 1'b1);
    check("stopped", busy | motion.enable, 1'b0);
    check("phases", ph, exp_ph);
    check("phase count", n, exp_n);
    check("home range", (home_pos >= lo) && (home_pos <= hi), 1'b1);
  endtask

  // Reserved or unsupported method
  task automatic refuse(input logic [7:0] method);
    place(1050);
    cmd = 1'b1;
    cfg = '{method, SP1, SP2};
    @(posedge core_clk);
    #1;
    cmd = 1'b0;
    check("refused", refused, 1'b1);
    check("busy refused", busy, 1'b0);
    @(posedge core_clk);
    #1;
    check("refused end", refused, 1'b0);
  endtask

  // Index methods with the home switch
  // A fast approach still travels four steps after the switch edge, so the
  // tooth just inside the switch window is the first index that counts
  task automatic index_methods();
    run(`HS_M11, 1300, 8'h03, 2, 1152, 1163);
    run(`HS_M11, 1050, 8'h03, 1, 1152, 1163);
    run(`HS_M12, 1300, 8'h01, 2, 1076, 1095);
    run(`HS_M12, 1050, 8'h0d, 2, 1084, 1095);
    run(`HS_M12, 800, 8'h21, 4, 1076, 1095);
    run(`HS_M13, 1050, 8'h07, 2, 1024, 1035);
    run(`HS_M13, 1300, 8'h01, 2, 1076, 1095);
    run(`HS_M13, 800, 8'h0b, 3, 1024, 1035);
    run(`HS_M14, 1300, 8'h01, 2, 956, 967);
    run(`HS_M14, 1050, 8'h01, 1, 956, 967);
    run(`HS_M14, 800, 8'h09, 3, 956, 967);
  endtask

  // Switch-only methods, index passes are ignored
  task automatic switch_methods();
    run(`HS_M17, 800, 8'h03, 2, 500, 506);
    run(`HS_M17, 450, 8'h03, 1, 500, 506);
    run(`HS_M18, 1400, 8'h09, 2, 1594, 1600);
    run(`HS_M18, 1650, 8'h01, 1, 1594, 1600);
    run(`HS_M19, 800, 8'h09, 2, 993, 999);
    run(`HS_M19, 1050, 8'h01, 1, 993, 999);
  endtask

  // Main sequence
  initial begin
    repeat (4) @(posedge core_clk);
    #1;
    rst_b = 1'b1;
    check("reset done", done, 1'b0);
    index_methods();
    switch_methods();
    refuse(`HS_M15);
    refuse(`HS_M16);
    final_report();
  end
endmodule // tb
